// >>> rtl/deviation_monitor_map.svh
// Register map, reset values and timing constants of the deviation monitor
// Behaviour
// R1 - Speed error over level raises alarm 42
// R2 - Thrust error over level raises alarm 42
// R3 - Low digit picks position or current method
// R4 - Excitation level follows programmed percent, 0-100
// R5 - Ident frequency used only for method 1/2
// R6 - Host keeps frequency below half loop response
// R7 - Ident amplitude used only for method 1/2
// R8 - Host tunes excitation after overload/detection alarms
// R9 - Host lowers amplitude after overload in detection
// R10 - Host never alters reserved factory settings
// R11 - Host servo-offs and cuts power on alarm
// R12 - Select digit enables position/speed/thrust checks
// R13 - Position error over level raises alarm 42
// R14 - Compare once per cycle, latch first exceed
`ifndef DEVIATION_MONITOR_MAP_SVH
`define DEVIATION_MONITOR_MAP_SVH
// ****************************************************************
// Byte offsets
// ****************************************************************
`define OFS_CHECK_SEL 6'h00
`define OFS_POS_LEVEL 6'h04
`define OFS_SPD_LEVEL 6'h08
`define OFS_THR_LEVEL 6'h0C
`define OFS_METHOD 6'h10
`define OFS_EXCITE 6'h14
`define OFS_FREQ 6'h18
`define OFS_AMPL 6'h1C
`define OFS_STATUS 6'h20
`define OFS_MASK 6'h24
`define OFS_CTRL 6'h28
`define OFS_ALARM 6'h2C
// ****************************************************************
// Reset values and limits
// ****************************************************************
`define RST_CHECK_SEL 16'h0003
`define RST_POS_LEVEL 16'h0032
`define RST_SPD_LEVEL 16'h03E8
`define RST_THR_LEVEL 16'h0064
`define RST_METHOD 16'h0010
`define RST_EXCITE 16'h001E
`define RST_FREQ 16'h0005
`define RST_AMPL 16'h0064
`define MIN_SPD_LEVEL 16'h0001
`define MAX_SPD_LEVEL 16'h1388
`define MIN_THR_LEVEL 16'h0001
`define MAX_THR_LEVEL 16'h03E8
`define MIN_POS_LEVEL 16'h0001
`define MAX_POS_LEVEL 16'h03E8
`define MAX_EXCITE 16'h0064
`define MIN_FREQ 16'h0001
`define MAX_FREQ 16'h01F4
`define MIN_AMPL 16'h0032
`define MAX_AMPL 16'h0064
`define ALARM_CODE 8'h42
// ****************************************************************
// Fields and timing
// ****************************************************************
`define SEL_POS_BIT 0
`define SEL_SPD_BIT 1
`define SEL_THR_BIT 2
`define CTRL_CLEAR_BIT 0
`define CTRL_PERIOD_US 10
`define CLK_MHZ 50
`define CTRL_PERIOD_CYC (`CTRL_PERIOD_US * `CLK_MHZ)
`endif

// >>> rtl/deviation_monitor_pkg.sv
// Types shared by the deviation monitor files
package deviation_monitor_pkg;
    typedef enum logic [1:0] {
        METHOD_NONE = 2'b00,
        METHOD_POSITION = 2'b01,
        METHOD_CURRENT = 2'b10
    } pole_method_e;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_e;
endpackage

// >>> rtl/level_clamp.sv
// Clamps a written setting into its legal range
`timescale 1ns/100ps
`default_nettype none
module level_clamp #(
    parameter int W = 16
) (
    // Value and limits
    input wire logic [W-1:0] rawVal,
    input wire logic [W-1:0] minVal,
    input wire logic [W-1:0] maxVal,
    // Result
    output logic [W-1:0] clampVal
);
    always_comb
    begin
        if (rawVal < minVal)
            clampVal = minVal;
        else if (rawVal > maxVal)
            clampVal = maxVal;
        else
            clampVal = rawVal;
    end
endmodule
`default_nettype wire

// >>> rtl/deviation_cmp.sv
// One deviation comparison: absolute difference against a level
`timescale 1ns/100ps
`default_nettype none
module deviation_cmp #(
    parameter int W = 24
) (
    // Operands signed, level unsigned, and enable
    input wire logic signed [W-1:0] refVal,
    input wire logic signed [W-1:0] measVal,
    input wire logic [15:0] level,
    input wire logic enable,
    // Result
    output logic exceed
);
    logic signed [W:0] diff;
    logic [W:0] mag;
    always_comb
    begin
        diff = {refVal[W-1], refVal} - {measVal[W-1], measVal};
        mag = diff[W] ? (W+1)'(-diff) : diff;
        exceed = enable && (mag > (W+1)'(level));
    end
endmodule
`default_nettype wire

// >>> rtl/linear_motor_deviation_monitor.sv
// Deviation monitor and pole detection settings of a linear servo drive
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "deviation_monitor_map.svh"
module linear_motor_deviation_monitor #(
    parameter int W = 24,
    parameter int CTRL_CYC = `CTRL_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Feedback from the motor side
    input wire logic signed [W-1:0] modelPos,
    input wire logic signed [W-1:0] measPos,
    input wire logic signed [W-1:0] modelSpd,
    input wire logic signed [W-1:0] measSpd,
    input wire logic signed [W-1:0] cmdThrust,
    input wire logic signed [W-1:0] measThrust,
    // Alarm and pole detection settings out
    output logic alarmOut,
    output logic [7:0] alarmCode,
    output logic irq,
    output logic [1:0] poleMethod,
    output logic [15:0] exciteLevel,
    output logic [15:0] identFreq,
    output logic [15:0] identAmpl,
    output logic identValid
);
    // ****************************************************************
    // Settings
    // ****************************************************************
    logic [15:0] selFf, posLvlFf, spdLvlFf, thrLvlFf;
    logic [15:0] methodFf, exciteFf, freqFf, amplFf;
    logic [2:0] statusFf, maskFf;
    logic [15:0] nxt_sel, nxt_posLvl, nxt_spdLvl, nxt_thrLvl;
    logic [15:0] nxt_method, nxt_excite, nxt_freq, nxt_ampl;
    logic [2:0] nxt_status, nxt_mask;
    logic [15:0] wd, cPos, cSpd, cThr, cExc, cFreq, cAmpl;
    logic acc, wrHit, rdHit;
    deviation_monitor_pkg::bus_state_e busFf, nxt_bus;

    assign wd = writedata[15:0];
    level_clamp #(.W(16)) uPos (.rawVal(wd), .minVal(`MIN_POS_LEVEL),
        .maxVal(`MAX_POS_LEVEL), .clampVal(cPos));
    level_clamp #(.W(16)) uSpd (.rawVal(wd), .minVal(`MIN_SPD_LEVEL),
        .maxVal(`MAX_SPD_LEVEL), .clampVal(cSpd));
    level_clamp #(.W(16)) uThr (.rawVal(wd), .minVal(`MIN_THR_LEVEL),
        .maxVal(`MAX_THR_LEVEL), .clampVal(cThr));
    level_clamp #(.W(16)) uExc (.rawVal(wd), .minVal(16'h0000),
        .maxVal(`MAX_EXCITE), .clampVal(cExc));
    level_clamp #(.W(16)) uFrq (.rawVal(wd), .minVal(`MIN_FREQ),
        .maxVal(`MAX_FREQ), .clampVal(cFreq));
    level_clamp #(.W(16)) uAmp (.rawVal(wd), .minVal(`MIN_AMPL),
        .maxVal(`MAX_AMPL), .clampVal(cAmpl));

    // ****************************************************************
    // Control cycle tick
    // ****************************************************************
    logic [15:0] tickCntFf, nxt_tickCnt;
    logic tickFf, nxt_tick;
    always_comb
    begin
        nxt_tick = 1'b0;
        nxt_tickCnt = tickCntFf + 16'h0001;
        if (tickCntFf == 16'(CTRL_CYC - 1))
        begin
            nxt_tickCnt = 16'h0000;
            nxt_tick = 1'b1;
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            tickCntFf <= 16'h0000;
            tickFf <= 1'b0;
        end
        else
        begin
            tickCntFf <= nxt_tickCnt;
            tickFf <= nxt_tick;
        end
    end

    // ****************************************************************
    // Comparisons
    // ****************************************************************
    logic exPos, exSpd, exThr, exAny, alarmFf, nxt_alarm, clearReq;
    deviation_cmp #(.W(W)) uCmpPos (.refVal(modelPos), .measVal(measPos),
        .level(posLvlFf), .enable(selFf[`SEL_POS_BIT]),
        .exceed(exPos)); // R13 R12
    deviation_cmp #(.W(W)) uCmpSpd (.refVal(modelSpd), .measVal(measSpd),
        .level(spdLvlFf), .enable(selFf[`SEL_SPD_BIT]),
        .exceed(exSpd)); // R1 R12
    deviation_cmp #(.W(W)) uCmpThr (.refVal(cmdThrust),
        .measVal(measThrust), .level(thrLvlFf),
        .enable(selFf[`SEL_THR_BIT]), .exceed(exThr)); // R2 R12
    assign exAny = exPos | exSpd | exThr;

    // Latched alarm; a new exceed wins over a clear in the same cycle
    always_comb
    begin
        nxt_alarm = alarmFf;
        if (clearReq)
            nxt_alarm = 1'b0;
        if (tickFf && exAny)
            nxt_alarm = 1'b1; // R14
    end

    // ****************************************************************
    // Register bus
    // ****************************************************************
    assign acc = (read | write) && busFf == deviation_monitor_pkg::BUS_IDLE;
    // Write lands in the answer cycle, request still held
    assign wrHit = write && busFf == deviation_monitor_pkg::BUS_ACK
        && byteenable[1:0] == 2'b11;
    assign rdHit = read && acc;
    assign clearReq = wrHit && address == `OFS_CTRL
        && writedata[`CTRL_CLEAR_BIT];

    always_comb
    begin
        nxt_sel = selFf;
        nxt_posLvl = posLvlFf;
        nxt_spdLvl = spdLvlFf;
        nxt_thrLvl = thrLvlFf;
        nxt_method = methodFf;
        nxt_excite = exciteFf;
        nxt_freq = freqFf;
        nxt_ampl = amplFf;
        nxt_mask = maskFf;
        nxt_bus = acc ? deviation_monitor_pkg::BUS_ACK
            : deviation_monitor_pkg::BUS_IDLE;
        if (wrHit)
        begin
            case (address)
                `OFS_CHECK_SEL: nxt_sel = {13'h0000, wd[2:0]};
                `OFS_POS_LEVEL: nxt_posLvl = cPos;
                `OFS_SPD_LEVEL: nxt_spdLvl = cSpd; // R1
                `OFS_THR_LEVEL: nxt_thrLvl = cThr; // R2
                `OFS_METHOD: nxt_method = wd;
                `OFS_EXCITE: nxt_excite = cExc; // R4
                `OFS_FREQ: nxt_freq = cFreq; // R5
                `OFS_AMPL: nxt_ampl = cAmpl; // R7
                `OFS_MASK: nxt_mask = wd[2:0];
                default: nxt_sel = selFf;
            endcase
        end
    end

    // Sticky status; read clears, new event wins
    always_comb
    begin
        nxt_status = statusFf;
        if (rdHit && address == `OFS_STATUS)
            nxt_status = 3'h0;
        if (tickFf)
            nxt_status = nxt_status | {exThr, exSpd, exPos};
    end

    logic [31:0] nxt_rd;
    always_comb
    begin
        nxt_rd = readdata;
        if (rdHit)
        begin
            case (address)
                `OFS_CHECK_SEL: nxt_rd = {16'h0000, selFf};
                `OFS_POS_LEVEL: nxt_rd = {16'h0000, posLvlFf};
                `OFS_SPD_LEVEL: nxt_rd = {16'h0000, spdLvlFf};
                `OFS_THR_LEVEL: nxt_rd = {16'h0000, thrLvlFf};
                `OFS_METHOD: nxt_rd = {16'h0000, methodFf};
                `OFS_EXCITE: nxt_rd = {16'h0000, exciteFf};
                `OFS_FREQ: nxt_rd = {16'h0000, freqFf};
                `OFS_AMPL: nxt_rd = {16'h0000, amplFf};
                `OFS_STATUS: nxt_rd = {29'h00000000, statusFf};
                `OFS_MASK: nxt_rd = {29'h00000000, maskFf};
                `OFS_ALARM: nxt_rd = {23'h000000, alarmCode, alarmFf};
                default: nxt_rd = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Pole detection outputs
    // ****************************************************************
    logic [1:0] nxt_poleMethod;
    logic nxt_identValid;
    always_comb
    begin
        case (methodFf[3:0]) // R3
            4'h1: nxt_poleMethod = deviation_monitor_pkg::METHOD_POSITION;
            4'h2: nxt_poleMethod = deviation_monitor_pkg::METHOD_CURRENT;
            default: nxt_poleMethod = deviation_monitor_pkg::METHOD_NONE;
        endcase
        nxt_identValid = methodFf[3:0] == 4'h1
            || methodFf[3:0] == 4'h2; // R5 R7
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            selFf <= `RST_CHECK_SEL;
            posLvlFf <= `RST_POS_LEVEL;
            spdLvlFf <= `RST_SPD_LEVEL;
            thrLvlFf <= `RST_THR_LEVEL;
            methodFf <= `RST_METHOD;
            exciteFf <= `RST_EXCITE;
            freqFf <= `RST_FREQ;
            amplFf <= `RST_AMPL;
            statusFf <= 3'h0;
            maskFf <= 3'h0;
            busFf <= deviation_monitor_pkg::BUS_IDLE;
            readdata <= 32'h00000000;
            waitrequest <= 1'b1;
            alarmFf <= 1'b0;
            alarmOut <= 1'b0;
            alarmCode <= 8'h00;
            irq <= 1'b0;
            poleMethod <= 2'b00;
            exciteLevel <= `RST_EXCITE;
            identFreq <= 16'h0000;
            identAmpl <= 16'h0000;
            identValid <= 1'b0;
        end
        else
        begin
            selFf <= nxt_sel;
            posLvlFf <= nxt_posLvl;
            spdLvlFf <= nxt_spdLvl;
            thrLvlFf <= nxt_thrLvl;
            methodFf <= nxt_method;
            exciteFf <= nxt_excite;
            freqFf <= nxt_freq;
            amplFf <= nxt_ampl;
            statusFf <= nxt_status;
            maskFf <= nxt_mask;
            busFf <= nxt_bus;
            readdata <= nxt_rd;
            // Low in the answer cycle only: one wait state
            waitrequest <= nxt_bus != deviation_monitor_pkg::BUS_ACK;
            alarmFf <= nxt_alarm;
            alarmOut <= nxt_alarm;
            alarmCode <= nxt_alarm ? `ALARM_CODE : 8'h00; // R1 R2 R13
            irq <= |(nxt_status & nxt_mask);
            poleMethod <= nxt_poleMethod;
            exciteLevel <= exciteFf; // R4
            // Zero when unused so the drive never sees stale figures
            identFreq <= nxt_identValid ? freqFf : 16'h0000; // R5
            identAmpl <= nxt_identValid ? amplFf : 16'h0000; // R7
            identValid <= nxt_identValid;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence exceedSeen;
        tickFf && exAny;
    endsequence
    sequence alarmUp;
        ##1 alarmFf && alarmOut && alarmCode == `ALARM_CODE;
    endsequence
    sequence statusReadSeen;
        rdHit && address == `OFS_STATUS && !tickFf;
    endsequence
    sequence clearOnlySeen;
        clearReq && !(tickFf && exAny);
    endsequence
    alarm_latch_a: assert property (@(posedge clk_sys) // R14
        disable iff (sys_rst) exceedSeen |-> alarmUp)
        else $error("Alarm not raised after exceed");
    speed_check_a: assert property (@(posedge clk_sys) // R1
        disable iff (sys_rst) tickFf && selFf[1] && exSpd |=> alarmFf)
        else $error("Speed deviation missed");
    thrust_check_a: assert property (@(posedge clk_sys) // R2
        disable iff (sys_rst) tickFf && exThr |=> alarmFf && statusFf[2])
        else $error("Thrust deviation missed");
    position_check_a: assert property (@(posedge clk_sys) // R13
        disable iff (sys_rst)
        tickFf && exPos && !clearReq |=> alarmFf && statusFf[0])
        else $error("Position deviation missed");
    select_gate_a: assert property (@(posedge clk_sys) // R12
        disable iff (sys_rst) !(exPos && !selFf[0])
        && !(exSpd && !selFf[1]) && !(exThr && !selFf[2]))
        else $error("Check fired while disabled");
    method_map_a: assert property (@(posedge clk_sys) // R3
        disable iff (sys_rst) methodFf[3:0] == 4'h2 |=> poleMethod == 2'b10)
        else $error("Current method not selected");
    method_pos_a: assert property (@(posedge clk_sys) // R3
        disable iff (sys_rst)
        methodFf[3:0] == 4'h1 |=> poleMethod == 2'b01 && identValid)
        else $error("Position method not selected");
    method_none_a: assert property (@(posedge clk_sys) // R3
        disable iff (sys_rst) !(methodFf[3:0] inside {4'h1, 4'h2})
        |=> poleMethod == 2'b00 && !identValid)
        else $error("Method decoded from unused code");
    excite_range_a: assert property (@(posedge clk_sys) // R4
        disable iff (sys_rst)
        ##1 exciteLevel <= `MAX_EXCITE && exciteLevel == $past(exciteFf))
        else $error("Excitation level wrong");
    ident_gate_a: assert property (@(posedge clk_sys) // R5
        disable iff (sys_rst)
        !identValid |-> identFreq == 16'h0000 && identAmpl == 16'h0000)
        else $error("Ident setting used while invalid");
    ident_freq_a: assert property (@(posedge clk_sys) // R5
        disable iff (sys_rst) identValid |-> identFreq == $past(freqFf))
        else $error("Ident frequency not passed on");
    ident_ampl_a: assert property (@(posedge clk_sys) // R7
        disable iff (sys_rst) identValid |-> identAmpl == $past(amplFf))
        else $error("Ident amplitude not passed on");
    ampl_range_a: assert property (@(posedge clk_sys) // R7
        disable iff (sys_rst) amplFf >= `MIN_AMPL && amplFf <= `MAX_AMPL)
        else $error("Amplitude out of range");
    speed_range_a: assert property (@(posedge clk_sys) // R1
        disable iff (sys_rst)
        spdLvlFf >= `MIN_SPD_LEVEL && spdLvlFf <= `MAX_SPD_LEVEL)
        else $error("Speed level out of range");
    thrust_range_a: assert property (@(posedge clk_sys) // R2
        disable iff (sys_rst)
        thrLvlFf >= `MIN_THR_LEVEL && thrLvlFf <= `MAX_THR_LEVEL)
        else $error("Thrust level out of range");
    status_set_a: assert property (@(posedge clk_sys) // R1
        disable iff (sys_rst) tickFf && exSpd |=> statusFf[1])
        else $error("Speed event not recorded");
    status_clear_a: assert property (@(posedge clk_sys) // R14
        disable iff (sys_rst) statusReadSeen |=> statusFf == 3'h0)
        else $error("Status not cleared by read");
    irq_level_a: assert property (@(posedge clk_sys) // R14
        disable iff (sys_rst) irq == |(statusFf & maskFf))
        else $error("Interrupt level wrong");
    alarm_hold_a: assert property (@(posedge clk_sys) // R14
        disable iff (sys_rst) alarmFf && !clearReq |=> alarmFf)
        else $error("Alarm dropped without clear");
    alarm_clear_a: assert property (@(posedge clk_sys) // R14
        disable iff (sys_rst) clearOnlySeen |=> !alarmFf && !alarmOut
        && alarmCode == 8'h00)
        else $error("Alarm not cleared");
    alarm_rise_a: assert property (@(posedge clk_sys) // R14
        disable iff (sys_rst) !tickFf && !alarmFf |=> !alarmFf)
        else $error("Alarm raised between ticks");
endmodule
`default_nettype wire

// >>> verif/motor_feedback_model.sv
// Behavioural linear motor with position, speed and thrust feedback
`timescale 1ns/100ps
`default_nettype none
module motor_feedback_model #(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Injected following errors
    input wire logic signed [W-1:0] posErr,
    input wire logic signed [W-1:0] spdErr,
    input wire logic signed [W-1:0] thrErr,
    // Feedback to the monitor
    output logic signed [W-1:0] modelPos,
    output logic signed [W-1:0] measPos,
    output logic signed [W-1:0] modelSpd,
    output logic signed [W-1:0] measSpd,
    output logic signed [W-1:0] cmdThrust,
    output logic signed [W-1:0] measThrust
);
    logic signed [W-1:0] travel_ff;
    // Axis keeps moving so no operand sits at a constant
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            travel_ff <= '0;
        end
        else
        begin
            travel_ff <= travel_ff + W'(3);
        end
    end
    always_comb
    begin
        modelPos = travel_ff;
        measPos = travel_ff - posErr;
        modelSpd = travel_ff >>> 2;
        measSpd = modelSpd - spdErr;
        cmdThrust = travel_ff >>> 4;
        measThrust = cmdThrust - thrErr;
    end
endmodule
`default_nettype wire

// >>> verif/linear_motor_deviation_monitor_tb.sv
// Register and alarm tests of the deviation monitor
`timescale 1ns/100ps
`default_nettype none
`include "deviation_monitor_map.svh"
module linear_motor_deviation_monitor_tb;
    localparam int W = 24;
    localparam int CYC = 4;
    typedef struct {
        logic [15:0] sel;
        int which;
        int err;
        logic [15:0] mask;
        logic hit;
    } devCase_s;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [3:0] byteenable = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic signed [W-1:0] pos0, pos1, spd0, spd1, thr0, thr1;
    logic signed [W-1:0] errTab [3] = '{default: '0};
    logic alarmOut, irq, identValid;
    logic [7:0] alarmCode;
    logic [1:0] poleMethod;
    logic [15:0] exciteLevel, identFreq, identAmpl;
    logic [31:0] rdVal;
    int errTotal = 0;
    int testsRun = 0;
    int cycleCount = 0;
    logic [15:0] rstTab [8] = '{`RST_CHECK_SEL, `RST_POS_LEVEL,
        `RST_SPD_LEVEL, `RST_THR_LEVEL, `RST_METHOD, `RST_EXCITE,
        `RST_FREQ, `RST_AMPL};
    logic [15:0] mthTab [4] = '{16'h0011, 16'h0012, 16'h0013, 16'h0021};
    logic [1:0] mthExp [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
    logic [5:0] clAdr [8] = '{6'h14, 6'h14, 6'h18, 6'h18, 6'h1C, 6'h08,
        6'h0C, 6'h04};
    logic [15:0] clIn [8] = '{16'h00C8, 16'h0000, 16'h0000, 16'h0258,
        16'h000A, 16'h1770, 16'h0000, 16'h07D0};
    logic [15:0] clExp [8] = '{16'h0064, 16'h0000, 16'h0001, 16'h01F4,
        16'h0032, 16'h1388, 16'h0001, 16'h03E8};
    devCase_s devTab [8] = '{'{16'h1, 0, 50, 16'h7, 1'b0},
        '{16'h1, 0, -51, 16'h7, 1'b1}, '{16'h2, 1, 1001, 16'h7, 1'b1},
        '{16'h2, 1, -1000, 16'h7, 1'b0}, '{16'h4, 2, 101, 16'h7, 1'b1},
        '{16'h3, 2, 5000, 16'h7, 1'b0}, '{16'h7, 1, -1001, 16'h0, 1'b1},
        '{16'h6, 0, 1000, 16'h7, 1'b0}};

    always #10 clk_sys = ~clk_sys;

    linear_motor_deviation_monitor #(.W(W), .CTRL_CYC(CYC))
        u_linear_motor_deviation_monitor (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .modelPos(pos0),
        .measPos(pos1), .modelSpd(spd0), .measSpd(spd1),
        .cmdThrust(thr0), .measThrust(thr1), .alarmOut(alarmOut),
        .alarmCode(alarmCode), .irq(irq), .poleMethod(poleMethod),
        .exciteLevel(exciteLevel), .identFreq(identFreq),
        .identAmpl(identAmpl), .identValid(identValid));

    motor_feedback_model #(.W(W)) u_motor_feedback_model (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .posErr(errTab[0]),
        .spdErr(errTab[1]), .thrErr(errTab[2]), .modelPos(pos0),
        .measPos(pos1), .modelSpd(spd0), .measSpd(spd1),
        .cmdThrust(thr0), .measThrust(thr1));

    task automatic results();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic busAccess(input logic isWr, input logic [5:0] adr,
        input logic [31:0] data, input logic [3:0] be);
        @(posedge clk_sys);
        address <= adr;
        writedata <= data;
        byteenable <= be;
        read <= ~isWr;
        write <= isWr;
        @(posedge clk_sys);
        while (waitrequest)
        begin
            @(posedge clk_sys);
        end
        rdVal = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] adr, input logic [15:0] data);
        busAccess(1'b1, adr, {16'h0000, data}, 4'hF);
    endtask

    task automatic rdCheck(input string what, input logic [5:0] adr,
        input logic [31:0] exp);
        busAccess(1'b0, adr, 32'h0, 4'h0);
        check(what, rdVal, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic doReset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
    endtask

    always @(posedge clk_sys)
    begin
        cycleCount++;
        if (cycleCount == 20000)
        begin
            errTotal++;
            results();
        end
    end

    // Reserved factory settings are never written
    // Excitation written up and down and amplitude only lowered, with no overload first
    initial
    begin
        doReset();
        check("exciteOut", 32'(exciteLevel), 32'h0000001E);
        for (int i = 0; i < 8; i++)
        begin
            rdCheck("resetValue", 6'(4 * i), 32'(rstTab[i]));
        end
        settle();
        check("methodOut", 32'(poleMethod), 32'h0);
        check("freqOff", 32'({identValid, identFreq}), 32'h0);
        check("amplOff", 32'(identAmpl), 32'h0);
        rdCheck("unmapped", 6'h30, 32'h0);
        // Frequency kept at its small default here
        for (int i = 0; i < 4; i++)
        begin
            wr(`OFS_METHOD, mthTab[i]);
            settle();
            check("method", 32'(poleMethod), 32'(mthExp[i]));
            check("identValid", 32'(identValid), 32'(mthExp[i] != 0));
            check("freq", 32'(identFreq), mthExp[i] != 0 ? 5 : 0);
            check("ampl", 32'(identAmpl), mthExp[i] != 0 ? 100 : 0);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(clAdr[i], clIn[i]);
            rdCheck("clamped", clAdr[i], 32'(clExp[i]));
        end
        settle();
        check("exciteZero", 32'(exciteLevel), 32'h0);
        busAccess(1'b1, `OFS_EXCITE, 32'h00000050, 4'hC);
        rdCheck("partialWrite", `OFS_EXCITE, 32'h0);
        doReset();
        check("exciteReset", 32'(exciteLevel), 32'h0000001E);
        foreach (devTab[i])
        begin
            wr(`OFS_MASK, devTab[i].mask);
            wr(`OFS_CHECK_SEL, devTab[i].sel);
            errTab[devTab[i].which] <= W'(devTab[i].err);
            for (int n = 0; n < 3 * CYC + 8 && alarmOut !== 1'b1; n++)
            begin
                @(negedge clk_sys);
            end
            if (!devTab[i].hit)
            begin
                repeat (3 * CYC + 8) @(negedge clk_sys);
            end
            check("alarmOut", 32'(alarmOut), 32'(devTab[i].hit));
            check("alarmCode", 32'(alarmCode),
                devTab[i].hit ? 32'h42 : 32'h0);
            check("irq", 32'(irq),
                32'(devTab[i].hit && devTab[i].mask != 0));
            // Servo off after an alarm removes the error
            @(posedge clk_sys);
            errTab[devTab[i].which] <= '0;
            repeat (2 * CYC + 4) @(posedge clk_sys);
            rdCheck("alarmLatch", `OFS_ALARM,
                devTab[i].hit ? 32'h85 : 32'h0);
            rdCheck("status", `OFS_STATUS,
                devTab[i].hit ? 32'(1 << devTab[i].which) : 32'h0);
            rdCheck("statusCleared", `OFS_STATUS, 32'h0);
            settle();
            check("irqCleared", 32'(irq), 32'h0);
            wr(`OFS_CTRL, 16'h0001);
            settle();
            check("alarmCleared", 32'(alarmOut), 32'h0);
        end
        results();
    end
endmodule
`default_nettype wire
